// ==== rtl/ot_map.svh ====
// Constants of the orientation and tap sensor core: offsets, fields, resets, times.
// Assumes a 100 MHz core clock and a register port with byte addresses.
`ifndef OT_MAP_SVH
`define OT_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OT_REG_CTRL      8'h00
`define OT_REG_DBLWIN    8'h04
`define OT_REG_STATE     8'h08
`define OT_REG_IRQSTAT   8'h0C
`define OT_REG_IRQMASK   8'h10

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define OT_CTRL_TAPEN    0
`define OT_CTRL_DBLEN    1
`define OT_CTRL_SELF     2
`define OT_CTRL_W        3
`define OT_DBLWIN_W      16
`define OT_ST_PORT       0
`define OT_ST_LAND       1
`define OT_ST_SIGN       2
`define OT_ST_VALID      3
`define OT_ST_PWR_LO     4
`define OT_ST_PWR_HI     5
`define OT_IRQ_ORIENT    0
`define OT_IRQ_SINGLE    1
`define OT_IRQ_DOUBLE    2
`define OT_IRQ_READY     3
`define OT_IRQ_W         4

// ****************************************************************
// Reset values
// ****************************************************************
`define OT_CTRL_RST      3'h3
`define OT_DBLWIN_RST    16'h1388
`define OT_IRQMASK_RST   4'h0

// ****************************************************************
// Axis codes from the measurement chain
// ****************************************************************
`define OT_AXIS_X        2'h0
`define OT_AXIS_Y        2'h1
`define OT_AXIS_Z        2'h2
`define OT_AXIS_NONE     2'h3

// ****************************************************************
// Times and derived cycle counts
// ****************************************************************
`define OT_CLK_MHZ       100
`define OT_CLK_KHZ       100000
`define OT_TON_MS        30
`define OT_STEADY_US     10
`define OT_STEADY_CYCLES (`OT_STEADY_US * `OT_CLK_MHZ)
`define OT_TAPHOLD_US    1
`define OT_TAPHOLD_CYCLES (`OT_TAPHOLD_US * `OT_CLK_MHZ)
`define OT_TON_W         22
`define OT_STEADY_W      12
`define OT_TAPHOLD_W     8

`endif

// ==== rtl/ot_pkg.sv ====
// Types shared by the orientation and tap sensor core.
// Assumes nothing beyond the constants header.
package ot_pkg;

    typedef logic [1:0] ot_axis_t;

    typedef enum logic [1:0] {
        PWR_DOWN,
        PWR_WAKE,
        PWR_RUN
    } ot_pwr_e;

    typedef enum logic {
        TAP_IDLE,
        TAP_WAIT
    } ot_tap_e;

endpackage : ot_pkg

// ==== rtl/ot_sync.sv ====
// Two-stage synchroniser, one per bit, for levels from outside the core clock.
// Assumes the inputs are levels held much longer than one clock period.
`timescale 1ns/100ps
`default_nettype none

module ot_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         clkEn,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    import ot_pkg::*;

    logic [W-1:0] stage1;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage1[i]  <= 1'b0;
                    syncOut[i] <= 1'b0;
                end else if (clkEn) begin
                    stage1[i]  <= asyncIn[i];
                    syncOut[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule : ot_sync

`default_nettype wire

// ==== rtl/ot_tap.sv ====
// Single and double click classifier fed by click edges.
// Assumes one-cycle click pulses on the core clock; clear holds it idle.
`timescale 1ns/100ps
`default_nettype none
`include "ot_map.svh"

module ot_tap (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic                    clkEn,
    input  wire logic                    clear,
    input  wire logic                    doubleEnable,
    input  wire logic [`OT_DBLWIN_W-1:0] window,
    input  wire logic                    click,
    output logic                         singleTap,
    output logic                         doubleTap
);
    import ot_pkg::*;

    ot_tap_e                 state;
    ot_tap_e                 next_state;
    logic [`OT_DBLWIN_W-1:0] waitCnt;
    logic                    windowOver;

    assign windowOver = (waitCnt >= window);

    always_comb begin
        next_state = state;
        case (state)
            TAP_IDLE: begin
                if (click && doubleEnable) begin
                    next_state = TAP_WAIT;
                end
            end
            TAP_WAIT: begin
                if (click || windowOver) begin
                    next_state = TAP_IDLE;
                end
            end
            default: next_state = TAP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= TAP_IDLE;
            waitCnt   <= '0;
            singleTap <= 1'b0;
            doubleTap <= 1'b0;
        end else if (clkEn) begin
            if (clear) begin
                state     <= TAP_IDLE;
                waitCnt   <= '0;
                singleTap <= 1'b0;
                doubleTap <= 1'b0;
            end else begin
                state     <= next_state;
                waitCnt   <= (state == TAP_WAIT) ? waitCnt + 1'b1 : '0;
                singleTap <= (state == TAP_IDLE && click && !doubleEnable)
                          || (state == TAP_WAIT && !click && windowOver);
                doubleTap <= (state == TAP_WAIT && click && !windowOver);
            end
        end
    end

endmodule : ot_tap

`default_nettype wire

// ==== rtl/ot_sensor_top.sv ====
// Pin-level digital core of a standalone orientation and click sensor.
// Assumes the measurement chain delivers axis, sign and click levels
// asynchronously, and that software reaches the registers on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "ot_map.svh"

module ot_sensor_top #(
    parameter int unsigned TURN_ON_CYCLES = `OT_TON_MS * `OT_CLK_KHZ
) (
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    input  wire logic            clkEn,
    input  wire logic            powerdown_n,
    input  wire ot_pkg::ot_axis_t axisSel,
    input  wire logic            axisNeg,
    input  wire logic            clickRaw,
    input  wire logic [7:0]      regAddr,
    input  wire logic [31:0]     regWdata,
    input  wire logic            regWrite,
    input  wire logic            regRead,
    output logic      [31:0]     regRdata,
    output logic                 portraitFlag,
    output logic                 landscapeFlag,
    output logic                 signFlag,
    output logic                 tapFlag,
    output logic                 chainEnable,
    output logic                 selfTestEnable,
    output logic                 outputsValid,
    output logic                 irq
);
    import ot_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [4:0]               syncIn;
    logic [4:0]               syncVal;
    logic                     pdSync;
    ot_axis_t                 axisSync;
    logic                     negSync;
    logic                     clickSync;
    logic                     clickPrev;
    logic                     clickRise;

    ot_pwr_e                  pwrState;
    ot_pwr_e                  next_pwrState;
    logic [`OT_TON_W-1:0]     tonCnt;
    logic                     tonDone;
    logic                     active;

    logic [2:0]               cand;
    logic [2:0]               lastCand;
    logic                     candValid;
    logic [`OT_STEADY_W-1:0]  steadyCnt;
    logic                     accept;
    logic [2:0]               orient;
    logic                     orientKnown;
    logic                     orientChange;
    logic                     next_portrait;
    logic                     next_landscape;
    logic                     next_sign;

    logic                     singleTap;
    logic                     doubleTap;
    logic                     tapEvent;
    logic [`OT_TAPHOLD_W-1:0] tapCnt;

    logic [`OT_CTRL_W-1:0]    ctrl;
    logic [`OT_DBLWIN_W-1:0]  dblWin;
    logic [`OT_IRQ_W-1:0]     irqStat;
    logic [`OT_IRQ_W-1:0]     irqMask;
    logic [`OT_IRQ_W-1:0]     irqEvents;
    logic [`OT_IRQ_W-1:0]     irqClear;
    logic [`OT_IRQ_W-1:0]     next_irqStat;
    logic                     readyRise;

    logic                     selCtrl;
    logic                     selDblWin;
    logic                     selState;
    logic                     selIrqStat;
    logic                     selIrqMask;
    logic [31:0]              stateWord;
    logic [31:0]              readMux;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    assign syncIn = {powerdown_n, axisSel, axisNeg, clickRaw};

    ot_sync #(
        .W (5)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .asyncIn  (syncIn),
        .syncOut  (syncVal)
    );

    assign pdSync    = syncVal[4];
    assign axisSync  = syncVal[3:2];
    assign negSync   = syncVal[1];
    assign clickSync = syncVal[0];
    // Pulses once per click.
    assign clickRise = clickSync & ~clickPrev;

    // ****************************************************************
    // Power sequencing
    // ****************************************************************
    // Marks the last turn-on cycle.
    assign tonDone = (tonCnt == `OT_TON_W'(TURN_ON_CYCLES - 1));
    assign active  = (pwrState == PWR_RUN);

    always_comb begin
        next_pwrState = pwrState;
        case (pwrState)
            PWR_DOWN: begin
                if (pdSync) begin
                    next_pwrState = PWR_WAKE;
                end
            end
            PWR_WAKE: begin
                if (!pdSync) begin
                    next_pwrState = PWR_DOWN;
                end else if (tonDone) begin
                    next_pwrState = PWR_RUN;
                end
            end
            PWR_RUN: begin
                if (!pdSync) begin
                    next_pwrState = PWR_DOWN;
                end
            end
            default: next_pwrState = PWR_DOWN;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwrState     <= PWR_DOWN;
            tonCnt       <= '0;
            outputsValid <= 1'b0;
        end else if (clkEn) begin
            pwrState     <= next_pwrState;
            tonCnt       <= (pwrState == PWR_WAKE) ? tonCnt + 1'b1 : '0;
            outputsValid <= (next_pwrState == PWR_RUN);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chainEnable    <= 1'b0;
            selfTestEnable <= 1'b0;
        end else if (clkEn) begin
            chainEnable    <= (next_pwrState != PWR_DOWN);
            selfTestEnable <= (next_pwrState != PWR_DOWN) && ctrl[`OT_CTRL_SELF];
        end
    end

    // ****************************************************************
    // Orientation classification
    // ****************************************************************
    assign cand      = {axisSync, negSync};
    assign candValid = (axisSync != `OT_AXIS_NONE);

    // Accepts after the steady time.
    assign accept    = active && candValid && (cand == lastCand)
                    && (steadyCnt == `OT_STEADY_W'(`OT_STEADY_CYCLES - 1));
    assign orientChange = accept && (!orientKnown || (orient != cand));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastCand    <= '0;
            steadyCnt   <= '0;
            orient      <= '0;
            orientKnown <= 1'b0;
        end else if (clkEn) begin
            lastCand <= cand;
            if (!active || !candValid || (cand != lastCand)) begin
                steadyCnt <= '0;
            end else if (!accept) begin
                steadyCnt <= steadyCnt + 1'b1;
            end
            if (!active) begin
                orientKnown <= 1'b0;
            end else if (accept) begin
                orient      <= cand;
                orientKnown <= 1'b1;
            end
        end
    end

    assign next_portrait  = orientKnown && (orient[2:1] == `OT_AXIS_Y);
    assign next_landscape = orientKnown && (orient[2:1] == `OT_AXIS_X);
    assign next_sign      = orientKnown && !orient[0];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            portraitFlag  <= 1'b0;
            landscapeFlag <= 1'b0;
            signFlag      <= 1'b0;
        end else if (clkEn) begin
            portraitFlag  <= next_portrait;
            landscapeFlag <= next_landscape;
            signFlag      <= next_sign;
        end
    end

    // ****************************************************************
    // Click detection
    // ****************************************************************
    ot_tap u_tap (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .clkEn        (clkEn),
        .clear        (!active || !ctrl[`OT_CTRL_TAPEN]),
        .doubleEnable (ctrl[`OT_CTRL_DBLEN]),
        .window       (dblWin),
        .click        (clickRise),
        .singleTap    (singleTap),
        .doubleTap    (doubleTap)
    );

    assign tapEvent = singleTap | doubleTap;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clickPrev <= 1'b0;
            tapCnt    <= '0;
            tapFlag   <= 1'b0;
        end else if (clkEn) begin
            clickPrev <= clickSync;
            if (!active) begin
                tapCnt  <= '0;
                tapFlag <= 1'b0;
            end else if (tapEvent) begin
                tapCnt  <= `OT_TAPHOLD_W'(`OT_TAPHOLD_CYCLES - 1);
                tapFlag <= 1'b1;
            end else if (tapCnt != '0) begin
                tapCnt  <= tapCnt - 1'b1;
            end else begin
                tapFlag <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Register decode
    // ****************************************************************
    assign selCtrl    = (regAddr == `OT_REG_CTRL);
    assign selDblWin  = (regAddr == `OT_REG_DBLWIN);
    assign selState   = (regAddr == `OT_REG_STATE);
    assign selIrqStat = (regAddr == `OT_REG_IRQSTAT);
    assign selIrqMask = (regAddr == `OT_REG_IRQMASK);

    assign stateWord = {26'h0000000, pwrState, outputsValid,
                        signFlag, landscapeFlag, portraitFlag};

    // Unknown offsets read as zero.
    assign readMux = selCtrl    ? {29'h00000000, ctrl}    :
                     selDblWin  ? {16'h0000, dblWin}      :
                     selState   ? stateWord               :
                     selIrqStat ? {28'h0000000, irqStat}  :
                     selIrqMask ? {28'h0000000, irqMask}  :
                     32'h00000000;

    // State is read-only.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl    <= `OT_CTRL_RST;
            dblWin  <= `OT_DBLWIN_RST;
            irqMask <= `OT_IRQMASK_RST;
        end else if (clkEn && regWrite) begin
            if (selCtrl) begin
                ctrl <= regWdata[`OT_CTRL_W-1:0];
            end
            if (selDblWin) begin
                dblWin <= regWdata[`OT_DBLWIN_W-1:0];
            end
            if (selIrqMask) begin
                irqMask <= regWdata[`OT_IRQ_W-1:0];
            end
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 32'h00000000;
        end else if (clkEn) begin
            regRdata <= regRead ? readMux : 32'h00000000;
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    assign readyRise = (next_pwrState == PWR_RUN) && !outputsValid;
    assign irqEvents = {readyRise, doubleTap, singleTap, orientChange};

    // Writing a one clears a bit.
    assign irqClear  = (regWrite && selIrqStat) ? regWdata[`OT_IRQ_W-1:0]
                                                : {`OT_IRQ_W{1'b0}};
    // A new event wins over a clear written in the same cycle.
    assign next_irqStat = (irqStat & ~irqClear) | irqEvents;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStat <= '0;
            irq     <= 1'b0;
        end else if (clkEn) begin
            irqStat <= next_irqStat;
            irq     <= |(next_irqStat & irqMask);
        end
    end

endmodule : ot_sensor_top

`default_nettype wire

// ==== sim/ot_checker.sv ====
// Timing checker for the orientation and tap core.
// Assumes one clock domain, rst_n asynchronous and active low.
`timescale 1ns/100ps
`default_nettype none
`include "ot_map.svh"

module ot_checker #(
    parameter int unsigned TURN_ON_CYCLES = 20
) (
    input wire logic             core_clk,
    input wire logic             rst_n,
    input wire logic             powerdown_n,
    input wire ot_pkg::ot_axis_t axisSel,
    input wire logic             axisNeg,
    input wire logic             portraitFlag,
    input wire logic             landscapeFlag,
    input wire logic             signFlag,
    input wire logic             tapFlag,
    input wire logic             chainEnable,
    input wire logic             selfTestEnable,
    input wire logic             outputsValid
);
    import ot_pkg::*;
    logic [7:0]  tapRun;
    logic [15:0] wakeRun;
    wire logic   axisIsX;
    wire logic   axisIsY;
    assign axisIsX = axisSel == `OT_AXIS_X;
    assign axisIsY = axisSel == `OT_AXIS_Y;
    // ************
    // Run lengths
    // ************
    // Saturating run lengths of the tap pulse and of the awake chain.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tapRun  <= 8'h00;
            wakeRun <= 16'h0000;
        end else begin
            tapRun  <= tapFlag ? tapRun + {7'h00, tapRun != 8'hFF} : 8'h00;
            wakeRun <= chainEnable ? wakeRun + {15'h0000, wakeRun != 16'hFFFF} : 16'h0000;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence pdHeldLow;
        !powerdown_n [*6];
    endsequence
    sequence pdRaised;
        $rose(powerdown_n) ##1 powerdown_n;
    endsequence
    chk_flags_exclusive: assert property (!(portraitFlag && landscapeFlag))
        else $error("Portrait and landscape high together.");
    chk_portrait_axis: assert property ($rose(portraitFlag) |-> $past(axisIsY, 5))
        else $error("Portrait rose without Y axis.");
    chk_landscape_axis: assert property ($rose(landscapeFlag) |-> $past(axisIsX, 5))
        else $error("Landscape rose without X axis.");
    chk_sign_polarity: assert property ($rose(signFlag) |-> !$past(axisNeg, 5))
        else $error("Sign rose on negative axis.");
    chk_wake_release: assert property (pdRaised |-> ##[0:4] chainEnable)
        else $error("Chain not woken after release.");
    chk_powerdown_quiet: assert property (pdHeldLow |-> !chainEnable && !outputsValid
        && !portraitFlag && !landscapeFlag && !signFlag && !tapFlag)
        else $error("Outputs active in power-down.");
    chk_turn_on_time: assert property ($rose(outputsValid) |->
        wakeRun >= TURN_ON_CYCLES - 1 && wakeRun <= TURN_ON_CYCLES + 2)
        else $error("Valid rose off the turn-on time.");
    chk_flags_valid: assert property (portraitFlag || landscapeFlag || signFlag
        |-> outputsValid || $past(outputsValid, 2))
        else $error("Flags set while not valid.");
    chk_tap_hold: assert property ($fell(tapFlag) && outputsValid |-> tapRun >= 8'h64)
        else $error("Tap pulse too short.");
    chk_selftest_chain: assert property (selfTestEnable |-> chainEnable || $past(chainEnable))
        else $error("Self-test with chain off.");
endmodule : ot_checker
`default_nettype wire

// ==== sim/ot_host_model.sv ====
// Host model: drives the power-down pin and samples the sensor lines.
// Assumes the lines change with no relation to core_clk.
`timescale 1ns/100ps
`default_nettype none

module ot_host_model #(
    parameter int unsigned TON = 20
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       wantRun,
    input  wire logic [3:0] lines,
    output logic            powerdown_n,
    output logic      [3:0] seenLines,
    output logic            seenFace,
    output logic            hostReady
);
    logic [3:0]  stage1;
    logic [15:0] upCount;
    assign seenFace  = !seenLines[0] && !seenLines[1];
    assign hostReady = upCount >= 16'(TON + 8);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            powerdown_n <= 1'b0;
            stage1      <= 4'h0;
            seenLines   <= 4'h0;
            upCount     <= 16'h0000;
        end else begin
            powerdown_n <= wantRun;
            stage1      <= lines;
            seenLines   <= stage1;
            upCount     <= powerdown_n ? upCount + {15'h0000, !hostReady} : 16'h0000;
        end
    end
endmodule : ot_host_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench of the orientation and tap core with a host model.
// Assumes the core, host model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ot_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin badCount++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module testbench;
    import ot_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wantRun = 1'b0;
    logic        powerdown_n, seenFace, hostReady, tapSeen;
    ot_axis_t    axisSel = `OT_AXIS_NONE;
    logic        axisNeg = 1'b0;
    logic        clickRaw = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [31:0] regRdata, rd;
    logic        portraitFlag, landscapeFlag, signFlag, tapFlag;
    logic        chainEnable, selfTestEnable, outputsValid, irq;
    logic [3:0]  seenLines;
    int          badCount = 0;
    int          checks = 0;
    int          cycles = 0;
    logic [7:0]  rstAddr[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] rstVal[6] = '{32'h3, 32'h1388, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [2:0]  tcCtrl[5] = '{3'h3, 3'h3, 3'h3, 3'h1, 3'h0};
    int          tcGap[5] = '{0, 15, 80, 0, 0};
    logic [3:0]  tcExp[5] = '{4'h2, 4'h4, 4'h2, 4'h2, 4'h0};

    ot_sensor_top #(.TURN_ON_CYCLES(20)) i_ot_sensor_top (
        .core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .powerdown_n(powerdown_n),
        .axisSel(axisSel), .axisNeg(axisNeg), .clickRaw(clickRaw), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .portraitFlag(portraitFlag), .landscapeFlag(landscapeFlag), .signFlag(signFlag),
        .tapFlag(tapFlag), .chainEnable(chainEnable), .selfTestEnable(selfTestEnable),
        .outputsValid(outputsValid), .irq(irq));
    ot_host_model #(.TON(20)) i_ot_host_model (
        .core_clk(core_clk), .rst_n(rst_n), .wantRun(wantRun),
        .lines({tapFlag, signFlag, landscapeFlag, portraitFlag}), .powerdown_n(powerdown_n),
        .seenLines(seenLines), .seenFace(seenFace), .hostReady(hostReady));

    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            badCount++;
            give_verdict();
        end
    end
    always @(posedge core_clk) if (seenLines[3] === 1'b1) tapSeen = 1'b1;

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 rd = regRdata;
    endtask : reg_rd
    task automatic click();
        @(posedge core_clk);
        clickRaw <= 1'b1;
        idle(5);
        clickRaw <= 1'b0;
        idle(5);
    endtask : click
    task automatic orient(input ot_axis_t ax, input logic ng, input logic [2:0] e);
        @(posedge core_clk);
        axisSel <= ax;
        axisNeg <= ng;
        idle(1100);
        `CHK("lines", e, seenLines[2:0])
        `CHK("face", e[1:0] == 2'h0, seenFace)
        reg_rd(`OT_REG_STATE);
        `CHK("state", {26'h0, 3'h5, e}, rd)
        `CHK("irqSet", 1'b1, irq)
        reg_wr(`OT_REG_IRQSTAT, 32'hF);
        idle(1);
        `CHK("irqClr", 1'b0, irq)
    endtask : orient
    task automatic wait_ready();
        for (int k = 0; k < 200 && hostReady !== 1'b1; k++) @(posedge core_clk);
        #1 `CHK("valid", 1'b1, outputsValid)
    endtask : wait_ready
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        tapSeen = 1'b0;
        idle(6);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            reg_rd(rstAddr[i]);
            `CHK("reset", rstVal[i], rd)
        end
        reg_wr(`OT_REG_IRQMASK, 32'h1);
        wantRun <= 1'b1;
        wait_ready();
        reg_rd(`OT_REG_IRQSTAT);
        `CHK("ready", 32'h8, rd & 32'h8)
        // Six orientations, then a wobble that must never be accepted.
        for (int i = 0; i < 6; i++) begin
            orient(i < 2 ? `OT_AXIS_X : i < 4 ? `OT_AXIS_Y : `OT_AXIS_Z, i[0],
                   i < 2 ? {~i[0], 2'h2} : i < 4 ? {~i[0], 2'h1} : {~i[0], 2'h0});
        end
        for (int i = 0; i < 8; i++) begin
            axisSel <= i[0] ? `OT_AXIS_Y : `OT_AXIS_X;
            idle(400);
        end
        `CHK("wobble", 3'h0, seenLines[2:0])
        orient(`OT_AXIS_Y, 1'b0, 3'h5);
        reg_wr(`OT_REG_DBLWIN, 32'h28);
        for (int i = 0; i < 5; i++) begin
            idle(150);
            reg_wr(`OT_REG_CTRL, {29'h0, tcCtrl[i]});
            reg_wr(`OT_REG_IRQSTAT, 32'hF);
            tapSeen = 1'b0;
            click();
            if (tcGap[i] > 0) begin
                idle(tcGap[i]);
                click();
            end
            idle(60);
            reg_rd(`OT_REG_IRQSTAT);
            `CHK("tapStat", {28'h0, tcExp[i]}, rd & 32'h6)
            `CHK("tapLine", tcExp[i] != 4'h0, tapSeen)
        end
        reg_wr(`OT_REG_CTRL, 32'h1);
        click();
        idle(20);
        `CHK("masked", 1'b0, irq)
        reg_wr(`OT_REG_IRQMASK, 32'h2);
        idle(2);
        `CHK("unmasked", 1'b1, irq)
        reg_wr(`OT_REG_CTRL, 32'h5);
        idle(2);
        `CHK("selfOn", 1'b1, selfTestEnable)
        wantRun <= 1'b0;
        idle(10);
        reg_rd(`OT_REG_STATE);
        `CHK("stateOff", 32'h0, rd)
        `CHK("chainOff", 1'b0, chainEnable)
        `CHK("selfOff", 1'b0, selfTestEnable)
        tapSeen = 1'b0;
        click();
        idle(20);
        `CHK("pdTap", 1'b0, tapSeen)
        wantRun <= 1'b1;
        idle(8);
        `CHK("early", 1'b0, outputsValid)
        wait_ready();
        give_verdict();
    end
endmodule : testbench

bind ot_sensor_top ot_checker #(.TURN_ON_CYCLES(TURN_ON_CYCLES)) i_ot_checker (
    .core_clk(core_clk), .rst_n(rst_n), .powerdown_n(powerdown_n), .axisSel(axisSel),
    .axisNeg(axisNeg), .portraitFlag(portraitFlag), .landscapeFlag(landscapeFlag),
    .signFlag(signFlag), .tapFlag(tapFlag), .chainEnable(chainEnable),
    .selfTestEnable(selfTestEnable), .outputsValid(outputsValid));
`default_nettype wire
